// >>> hdl/his_pkg.sv
/*
 Package for the two-channel serial controller interrupt/status block:
 register offsets, bit positions, reset values and the carrier structs.
 Assumes a 32-bit AXI4-Lite register port with word-aligned registers.
*/
package his_pkg;
   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFF_PRIMARY_IRQ_STATUS_A  = 8'h00;
   localparam logic [7:0] OFF_EXT_A   = 8'h04;
   localparam logic [7:0] OFF_CHANNEL_B_INTERRUPT_STATUS  = 8'h08;
   localparam logic [7:0] OFF_EXT_B   = 8'h0C;
   localparam logic [7:0] OFF_MASK_A  = 8'h10;
   localparam logic [7:0] OFF_MASK_B  = 8'h14;
   localparam logic [7:0] OFF_TXH_A   = 8'h18;
   localparam logic [7:0] OFF_TXH_B   = 8'h1C;
   localparam logic [7:0] OFF_TXL_A   = 8'h20;
   localparam logic [7:0] OFF_TXL_B   = 8'h24;
   localparam logic [7:0] OFF_CTL2_A  = 8'h28;
   localparam logic [7:0] OFF_CTL2_B  = 8'h2C;
   localparam logic [7:0] OFF_CMD_A   = 8'h30;
   localparam logic [7:0] OFF_CMD_B   = 8'h34;
   localparam logic [7:0] OFF_BYTES_A = 8'h38;
   localparam logic [7:0] OFF_BYTES_B = 8'h3C;

   // Primary status bit positions (channel B low three are pointers)
   localparam int P_PTR_EXB = 0;
   localparam int P_PTR_EXA = 1;
   localparam int P_PTR_ICA = 2;
   localparam int P_XPR     = 3;
   localparam int P_RFS_RSV = 4;
   localparam int P_RPF     = 5;
   localparam int P_RME     = 6;
   localparam int P_SPARE   = 7;
   // Extended status bit positions
   localparam int E_XDU = 0;
   localparam int E_XMR = 1;
   localparam int E_RFO = 2;
   localparam int E_RFS = 3;
   localparam int E_R4  = 4;
   localparam int E_R5  = 5;
   // Tx count high: DMA select and count bits 11:8
   localparam int TXH_DMA = 7;
   // Control two: receive-start enable
   localparam int CTL2_RIE = 0;
   // Command bits
   localparam int CMD_TRANSMITTER_RESET_CMD = 0;
   localparam int CMD_XTF  = 1;
   localparam int CMD_XIF  = 2;
   localparam int CMD_XME  = 3;

   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] ZERO8    = 8'h00;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   // Event inputs from the channel datapath, one-cycle pulses except the tx_queue_empty level
   typedef struct packed {
      logic rx_pool_full_ev;   // 32 bytes held, message incomplete
      logic rx_msg_done_ev;    // closing flag stored
      logic rx_dma_read_done;  // DMA drained the message
      logic rx_queue_full_new; // new frame start with queue full
      logic rx_start_ev;       // two bytes after address/flag
      logic tx_half_empty_ev;  // transmit half emptied
      logic tx_frame_done_ev;  // transparent CRC and flag out
      logic tx_pos_ack_ev;     // auto mode positive ack
      logic tx_neg_ack_ev;     // auto mode negative ack
      logic tx_retry_ev;       // collision / CTS loss past byte 32
      logic tx_byte_out;       // one byte shifted out
      logic tx_queue_empty;    // level: nothing left to send
   } his_ev_t;

   typedef struct packed {
      logic [7:0]  primary_irq_status;
      logic [5:0]  ext;
      logic [7:0]  mask;
      logic [7:0]  txh;
      logic [7:0]  txl;
      logic [7:0]  ctl2;
      logic        sending;
      logic        message_end_indication;
      logic        udr_done;
      logic [11:0] bytes;
   } his_chan_t;
endpackage

// >>> hdl/his_top.sv
/*
 Interrupt and transfer-mode logic for two serial channels: per-channel
 primary/extended status, mask, DMA select, one active-low interrupt.
 Assumes the datapath delivers events as one-cycle pulses on clk_sys and
 an AXI4-Lite master keeps to one write and one read at a time.
*/
// The AXI4-Lite register port and the address map were decided locally.
// Functional notes
// - After reset channels use interrupt mode; DMA only when tx count high bit set.
// - Each channel keeps its own interrupt-or-DMA mode selection.
// - All events of both channels share one active-low interrupt output.
// - Three primary and four extended indications per channel.
// - Channel B primary bits 2-0 point to pending A primary, A extended, B extended.
// - Channel B primary bits 7-3 show channel B sources directly.
// - Line stays low until every source cleared; reading a status register clears it.
// - A set mask bit stops its primary indication from requesting an interrupt.
// - Pool-full raised in interrupt mode at 32 bytes of an incomplete message.
// - Interrupt mode: message end raised once CRC and closing flag stored.
// - DMA mode: message end raised after DMA has read the whole message.
// - Frame overflow raised when queue full and a new frame starts.
// - Frame start raised two bytes in, only when its enable bit is set.
// - Control, address and low receive status are valid at frame start; no register here reads rx_ctl_field_a/b.
// - Pool-ready raised when a transmit half empties, and after transmitter reset.
// - Interrupt mode: pool-ready repeats until end-of-message, and at transparent frame end.
// - Auto mode: pool-ready raised on positive acknowledgement.
// - Auto mode: message-repeat raised on negative acknowledgement.
// - Message-repeat also raised on collision or CTS loss after byte 32.
// - Underrun raised when queue empty and all shifted without end-of-message.
`timescale 1ns/1ps
module his_top #(
   parameter int CHANNELS = 2
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]   s_awaddr,
   input  wire logic         s_awvalid,
   output logic              s_awready,
   input  wire logic [31:0]  s_wdata,
   input  wire logic [3:0]   s_wstrb,
   input  wire logic         s_wvalid,
   output logic              s_wready,
   output logic [1:0]        s_bresp,
   output logic              s_bvalid,
   input  wire logic         s_bready,
   input  wire logic [7:0]   s_araddr,
   input  wire logic         s_arvalid,
   output logic              s_arready,
   output logic [31:0]       s_rdata,
   output logic [1:0]        s_rresp,
   output logic              s_rvalid,
   input  wire logic         s_rready,
   // Datapath events per channel (index 0 = A, 1 = B)
   input  wire his_pkg::his_ev_t ev_a,
   input  wire his_pkg::his_ev_t ev_b,
   // Receive header values latched by the datapath
   input  wire logic [7:0]   rx_ctl_field_a,
   input  wire logic [7:0]   rx_ctl_field_b,
   // Mode outputs and the active-low interrupt line
   output logic              dma_mode_a,
   output logic              dma_mode_b,
   output logic              rx_start_irq_enable_a,
   output logic              rx_start_irq_enable_b,
   output logic              irq_n
);
   initial begin
      if (CHANNELS != 2) $error("his_top serves exactly two channels");
   end

   typedef struct packed {
      his_pkg::his_chan_t [1:0] ch;
      logic              aw_got;
      logic              w_got;
      logic [7:0]        aw_addr;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [1:0]        bresp;
      logic              irq;
   } his_state_t;

   his_state_t st_ff;
   his_state_t nxt_st;
   logic       rst_s1_ff;
   logic       rst_s2_ff;
   his_pkg::his_ev_t ev [1:0];

   assign ev[0] = ev_a;
   assign ev[1] = ev_b;

   // Reset release synchroniser
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end

   // Pending summary of one channel's primary bits, after mask
   function automatic logic prim_pend(input logic [7:0] s, input logic [7:0] m);
      prim_pend = |(s[7:3] & ~m[7:3]);
   endfunction

   // Pointer bits for channel B primary, live from the other registers
   function automatic logic [7:0] channel_b_interrupt_status_view(input his_state_t s);
      logic [7:0] v;
      v = s.ch[1].primary_irq_status;
      v[his_pkg::P_PTR_ICA] = prim_pend(s.ch[0].primary_irq_status, s.ch[0].mask);
      v[his_pkg::P_PTR_EXA] = |s.ch[0].ext;
      v[his_pkg::P_PTR_EXB] = |s.ch[1].ext;
      channel_b_interrupt_status_view = v;
   endfunction

   logic [7:0]  channel_b_interrupt_status_now;
   logic        wr_fire;
   logic        rd_fire;

   // Channel B primary as the host sees it, pointers included
   assign channel_b_interrupt_status_now = channel_b_interrupt_status_view(st_ff);
   logic [31:0] rd_word;
   logic        rd_hit;

   assign s_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_wready  = !st_ff.w_got && !st_ff.bvalid;
   assign s_arready = !st_ff.rvalid;
   assign rd_fire   = s_arvalid && s_arready;

   // Read decode; word-aligned, unmapped answers SLVERR
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (s_araddr == his_pkg::OFF_PRIMARY_IRQ_STATUS_A) begin
         rd_word[7:0] = st_ff.ch[0].primary_irq_status;
      end else if (s_araddr == his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS) begin
         rd_word[7:0] = channel_b_interrupt_status_now;
      end else if (s_araddr == his_pkg::OFF_EXT_A) begin
         rd_word[5:0] = st_ff.ch[0].ext;
      end else if (s_araddr == his_pkg::OFF_EXT_B) begin
         rd_word[5:0] = st_ff.ch[1].ext;
      end else if (s_araddr == his_pkg::OFF_MASK_A) begin
         rd_word[7:0] = st_ff.ch[0].mask;
      end else if (s_araddr == his_pkg::OFF_MASK_B) begin
         rd_word[7:0] = st_ff.ch[1].mask;
      end else if (s_araddr == his_pkg::OFF_TXH_A) begin
         rd_word[7:0] = st_ff.ch[0].txh;
      end else if (s_araddr == his_pkg::OFF_TXH_B) begin
         rd_word[7:0] = st_ff.ch[1].txh;
      end else if (s_araddr == his_pkg::OFF_TXL_A) begin
         rd_word[7:0] = st_ff.ch[0].txl;
      end else if (s_araddr == his_pkg::OFF_TXL_B) begin
         rd_word[7:0] = st_ff.ch[1].txl;
      end else if (s_araddr == his_pkg::OFF_CTL2_A) begin
         rd_word[7:0] = st_ff.ch[0].ctl2;
      end else if (s_araddr == his_pkg::OFF_CTL2_B) begin
         rd_word[7:0] = st_ff.ch[1].ctl2;
      end else if (s_araddr == his_pkg::OFF_CMD_A || s_araddr == his_pkg::OFF_CMD_B) begin
         rd_word = 32'h0000_0000; // Commands read as zero
      end else if (s_araddr == his_pkg::OFF_BYTES_A) begin
         rd_word[11:0] = st_ff.ch[0].bytes;
      end else if (s_araddr == his_pkg::OFF_BYTES_B) begin
         rd_word[11:0] = st_ff.ch[1].bytes;
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign wr_fire = (st_ff.aw_got || s_awvalid) && (st_ff.w_got || s_wvalid) && !st_ff.bvalid;

   // Next-state: bus slave, event capture, clear-on-read, interrupt
   always_comb begin
      logic [7:0]  wa;
      logic [31:0] wd;
      logic        wl;
      logic        dma;
      logic [11:0] cnt;
      logic        end_of_message_cmd;
      logic        transmitter_reset_cmd;
      logic        send_transparent_cmd;
      logic [7:0]  sp;
      logic [5:0]  se;
      logic        any;
      nxt_st = st_ff;
      wa  = st_ff.aw_got ? st_ff.aw_addr : s_awaddr;
      wd  = st_ff.w_got ? st_ff.w_data : s_wdata;
      wl  = st_ff.w_got ? st_ff.w_strb[0] : s_wstrb[0];
      dma = 1'b0;
      cnt = 12'h000;
      end_of_message_cmd = 1'b0;
      transmitter_reset_cmd = 1'b0;
      send_transparent_cmd = 1'b0;
      sp  = 8'h00;
      se  = 6'h00;
      any = 1'b0;

      // Address and data may arrive in either order
      if (s_awvalid && s_awready && !wr_fire) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_awaddr;
      end
      if (s_wvalid && s_wready && !wr_fire) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.w_data = s_wdata;
         nxt_st.w_strb = s_wstrb;
      end
      if (st_ff.bvalid && s_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.rvalid && s_rready) begin
         nxt_st.rvalid = 1'b0;
      end

      // Clear-on-read comes first so a same-cycle event wins
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd_word;
         nxt_st.rresp  = rd_hit ? his_pkg::RESP_OK : his_pkg::RESP_ERR;
         if (s_araddr == his_pkg::OFF_PRIMARY_IRQ_STATUS_A) nxt_st.ch[0].primary_irq_status = his_pkg::ZERO8;
         if (s_araddr == his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS) nxt_st.ch[1].primary_irq_status = his_pkg::ZERO8;
         if (s_araddr == his_pkg::OFF_EXT_A)  nxt_st.ch[0].ext  = 6'h00;
         if (s_araddr == his_pkg::OFF_EXT_B)  nxt_st.ch[1].ext  = 6'h00;
      end

      for (int c = 0; c < 2; c++) begin
         end_of_message_cmd = 1'b0;
         transmitter_reset_cmd = 1'b0;
         send_transparent_cmd = 1'b0;
         // Register writes; only the low byte lane carries data
         if (wr_fire && wl) begin
            if (wa == (c == 0 ? his_pkg::OFF_MASK_A : his_pkg::OFF_MASK_B)) begin
               nxt_st.ch[c].mask = wd[7:0];
            end else if (wa == (c == 0 ? his_pkg::OFF_TXH_A : his_pkg::OFF_TXH_B)) begin
               nxt_st.ch[c].txh = wd[7:0];
            end else if (wa == (c == 0 ? his_pkg::OFF_TXL_A : his_pkg::OFF_TXL_B)) begin
               nxt_st.ch[c].txl = wd[7:0];
            end else if (wa == (c == 0 ? his_pkg::OFF_CTL2_A : his_pkg::OFF_CTL2_B)) begin
               nxt_st.ch[c].ctl2 = wd[7:0];
            end else if (wa == (c == 0 ? his_pkg::OFF_CMD_A : his_pkg::OFF_CMD_B)) begin
               transmitter_reset_cmd = wd[his_pkg::CMD_TRANSMITTER_RESET_CMD];
               send_transparent_cmd  = wd[his_pkg::CMD_XTF] | wd[his_pkg::CMD_XIF];
               end_of_message_cmd  = wd[his_pkg::CMD_XME];
            end
         end
         dma = st_ff.ch[c].txh[his_pkg::TXH_DMA];
         cnt = {st_ff.ch[c].txh[3:0], st_ff.ch[c].txl};
         sp = 8'h00;
         se = 6'h00;

         // Receive events
         sp[his_pkg::P_RPF] = ev[c].rx_pool_full_ev && !dma;
         sp[his_pkg::P_RME] = dma ? ev[c].rx_dma_read_done : ev[c].rx_msg_done_ev;
         se[his_pkg::E_RFO] = ev[c].rx_queue_full_new;
         // Header registers are latched by the datapath before this pulse
         se[his_pkg::E_RFS] = ev[c].rx_start_ev && st_ff.ch[c].ctl2[his_pkg::CTL2_RIE];

         // Transmit pool ready: reset cmd, emptied half in DMA or while sending, frame end outside DMA, ack
         sp[his_pkg::P_XPR] = transmitter_reset_cmd
                            || (ev[c].tx_half_empty_ev && (dma || st_ff.ch[c].sending))
                            || (ev[c].tx_frame_done_ev && !dma)
                            || ev[c].tx_pos_ack_ev;
         se[his_pkg::E_XMR] = ev[c].tx_neg_ack_ev || ev[c].tx_retry_ev;

         // Message-end tracking and byte count
         if (transmitter_reset_cmd || send_transparent_cmd) begin
            nxt_st.ch[c].sending  = !transmitter_reset_cmd && send_transparent_cmd;
            nxt_st.ch[c].message_end_indication      = 1'b0;
            nxt_st.ch[c].bytes    = 12'h000;
            nxt_st.ch[c].udr_done = 1'b0;
         end else begin
            if (end_of_message_cmd && !dma) begin
               nxt_st.ch[c].message_end_indication     = 1'b1;
               nxt_st.ch[c].sending = 1'b0;
            end
            if (ev[c].tx_byte_out) begin
               nxt_st.ch[c].bytes = st_ff.ch[c].bytes + 12'h001;
               if (dma && (st_ff.ch[c].bytes + 12'h001) == cnt) begin
                  nxt_st.ch[c].message_end_indication = 1'b1;
               end
            end
            if (!ev[c].tx_queue_empty) nxt_st.ch[c].udr_done = 1'b0;
         end
         // Underrun once per empty episode without message end
         if (ev[c].tx_queue_empty && !st_ff.ch[c].message_end_indication && !st_ff.ch[c].udr_done
             && st_ff.ch[c].bytes != 12'h000 && !transmitter_reset_cmd && !send_transparent_cmd) begin
            se[his_pkg::E_XDU]        = 1'b1;
            nxt_st.ch[c].udr_done     = 1'b1;
         end

         nxt_st.ch[c].primary_irq_status[7:3] = nxt_st.ch[c].primary_irq_status[7:3] | sp[7:3];
         nxt_st.ch[c].ext       = nxt_st.ch[c].ext | se;
         nxt_st.ch[c].primary_irq_status[2:0] = 3'h0;
      end

      if (wr_fire) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bresp  = his_pkg::RESP_OK;
      end

      // Single shared line over all unmasked pending indications
      any = prim_pend(nxt_st.ch[0].primary_irq_status, nxt_st.ch[0].mask)
          || prim_pend(nxt_st.ch[1].primary_irq_status, nxt_st.ch[1].mask)
          || (|nxt_st.ch[0].ext) || (|nxt_st.ch[1].ext);
      nxt_st.irq = any;
   end

   // State register, reset to interrupt mode and all clear
   always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
      if (!rst_s2_ff) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_bvalid = st_ff.bvalid;
   assign s_bresp  = st_ff.bresp;
   assign s_rvalid = st_ff.rvalid;
   assign s_rdata  = st_ff.rdata;
   assign s_rresp  = st_ff.rresp;
   assign dma_mode_a = st_ff.ch[0].txh[his_pkg::TXH_DMA];
   assign dma_mode_b = st_ff.ch[1].txh[his_pkg::TXH_DMA];
   assign rx_start_irq_enable_a = st_ff.ch[0].ctl2[his_pkg::CTL2_RIE];
   assign rx_start_irq_enable_b = st_ff.ch[1].ctl2[his_pkg::CTL2_RIE];
   assign irq_n = !st_ff.irq;

   // Assertions
   irq_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (|st_ff.ch[1].ext) |-> !irq_n) else $error("irq not low with ext B pending");
   irq_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (st_ff.ch[0].primary_irq_status == 8'h00 && st_ff.ch[1].primary_irq_status == 8'h00 && st_ff.ch[0].ext == 6'h00
       && st_ff.ch[1].ext == 6'h00) |-> irq_n) else $error("irq low with nothing pending");
   read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (rd_fire && s_araddr == his_pkg::OFF_EXT_A && ev_a == '0) |=> st_ff.ch[0].ext == 6'h00)
      else $error("ext A not cleared by read");
   rpf_dma_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (ev_a.rx_pool_full_ev && dma_mode_a && !st_ff.ch[0].primary_irq_status[his_pkg::P_RPF])
      |=> !st_ff.ch[0].primary_irq_status[his_pkg::P_RPF]) else $error("pool full raised in DMA mode");
   rpf_only_int_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (ev_a.rx_pool_full_ev && !dma_mode_a) |=> st_ff.ch[0].primary_irq_status[his_pkg::P_RPF])
      else $error("pool full lost");
   rfs_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (ev_b.rx_start_ev && rx_start_irq_enable_b) |=> st_ff.ch[1].ext[his_pkg::E_RFS])
      else $error("frame start lost");
   mask_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (st_ff.ch[1].mask == 8'hFF && st_ff.ch[0].primary_irq_status == 8'h00 && st_ff.ch[0].ext == 6'h00
       && st_ff.ch[1].ext == 6'h00) |-> irq_n) else $error("masked primary raised irq");
   ptr_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (|st_ff.ch[0].ext) |-> channel_b_interrupt_status_now[his_pkg::P_PTR_EXA])
      else $error("ext A pointer missing");
   xmr_set_a: assert property (@(posedge clk_sys) disable iff (!rst_s2_ff)
      (ev_b.tx_neg_ack_ev || ev_b.tx_retry_ev) |=> st_ff.ch[1].ext[his_pkg::E_XMR])
      else $error("repeat lost");
endmodule // his_top

// >>> testbench/his_host_model.sv
/*
 Host CPU model: register accesses over AXI4-Lite and the mask re-edge step.
 Assumes one caller at a time and a clk_sys shared with the block.
*/
`timescale 1ns/1ps
module his_host_model (
   input  wire logic        clk_sys,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic        rvalid,
   output logic             rready
);
   logic ta, tw, tr;
   // Quiet bus from time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   end
   // Handshakes judged at negedge, so the taking edge never races the slave
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tr = bvalid;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tr);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
      rready <= 1'b0;
   endtask
   // Fresh edge for edge-triggered hosts: mask all, then restore
   task automatic reedge(input logic [7:0] a, input logic [7:0] old);
      wr(a, 32'h000000FF);
      wr(a, {24'h000000, old});
   endtask
endmodule // his_host_model

// >>> testbench/his_top_test.sv
/*
 Self-checking bench for his_top: host model on the register port, bench on events.
 Assumes read answers stand until taken and events are one-cycle pulses.
*/
`timescale 1ns/1ps
module his_top_test;
   logic             clk_sys, rst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic             s_arvalid, s_arready, s_rvalid, s_rready, dma_a, dma_b, rie_a, rie_b, irq_n;
   logic [7:0]       s_awaddr, s_araddr, ctl_a, ctl_b, m;
   logic [31:0]      s_wdata, s_rdata;
   logic [3:0]       s_wstrb;
   logic [1:0]       s_bresp, s_rresp;
   his_pkg::his_ev_t ev_a, ev_b;
   logic [33:0]      exq[$];
   int               checks, n_fail, cyc;
   // Event masks (struct bit order) and expected status, channel B
   localparam logic [11:0] EVM [8] = '{12'h800, 12'h400, 12'h040, 12'h020, 12'h010, 12'h100, 12'h008, 12'h004};
   localparam logic [7:0]  EXP [8] = '{8'h20, 8'h40, 8'h08, 8'h08, 8'h08, 8'h04, 8'h02, 8'h02};

   his_host_model host_u (.clk_sys, .awaddr(s_awaddr), .awvalid(s_awvalid), .awready(s_awready),
      .wdata(s_wdata), .wstrb(s_wstrb), .wvalid(s_wvalid), .wready(s_wready), .bvalid(s_bvalid),
      .bready(s_bready), .araddr(s_araddr), .arvalid(s_arvalid), .arready(s_arready),
      .rvalid(s_rvalid), .rready(s_rready));
   his_top dut_u (.clk_sys, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .ev_a, .ev_b, .rx_ctl_field_a(ctl_a), .rx_ctl_field_b(ctl_b),
      .dma_mode_a(dma_a), .dma_mode_b(dma_b), .rx_start_irq_enable_a(rie_a),
      .rx_start_irq_enable_b(rie_b), .irq_n);

   // 20 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h saw %h", nm, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      exq.push_back({his_pkg::RESP_OK, 24'h000000, d});
      host_u.rd(a);
   endtask
   // One-cycle event pulse on channel A (0) or B (1)
   task automatic pe(input logic ch, input logic [11:0] v);
      @(posedge clk_sys);
      if (ch) ev_b <= his_pkg::his_ev_t'(v);
      else ev_a <= his_pkg::his_ev_t'(v);
      @(posedge clk_sys);
      ev_a <= '0;
      ev_b <= '0;
   endtask
   // Registered line: give it one full cycle to settle
   task automatic irq_is(input logic v);
      repeat (2) @(negedge clk_sys);
      chk("irq_n", {33'h0, irq_n}, {33'h0, v});
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Oldest note meets each read answer; negedge avoids racing the answer flops
   always @(negedge clk_sys) begin
      if (s_rvalid && s_rready) begin
         if (exq.size() == 0) chk("rd_extra", 34'h1, 34'h0);
         else chk("rdata", {s_rresp, s_rdata}, exq.pop_front());
      end
      if (s_bvalid && s_bready) chk("bresp", {32'h0, s_bresp}, {32'h0, his_pkg::RESP_OK});
   end
   // Hang guard, far above the run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_n, ev_a, ev_b} = '0;
      void'($urandom(5565));
      ctl_a = 8'($urandom);
      ctl_b = 8'($urandom);
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("dma_a", {33'h0, dma_a}, 34'h0);
      chk("irq_rst", {33'h0, irq_n}, 34'h1);
      rd(his_pkg::OFF_MASK_A, his_pkg::MASK_RST);
      // Channel A to DMA, B stays on interrupts
      host_u.wr(his_pkg::OFF_TXH_A, 32'h00000080);
      @(negedge clk_sys);
      chk("dma_a", {33'h0, dma_a}, 34'h1);
      chk("dma_b", {33'h0, dma_b}, 34'h0);
      pe(0, 12'h800);
      pe(0, 12'h400);
      irq_is(1);
      pe(0, 12'h200);
      irq_is(0);
      rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h04);
      rd(his_pkg::OFF_PRIMARY_IRQ_STATUS_A, 8'h40);
      irq_is(1);
      // DMA count of one byte gives end-of-message, so no underrun
      host_u.wr(his_pkg::OFF_TXL_A, 32'h00000001);
      host_u.wr(his_pkg::OFF_CMD_A, 32'h00000002);
      pe(0, 12'h002);
      pe(0, 12'h001);
      irq_is(1);
      host_u.wr(his_pkg::OFF_TXH_A, 32'h00000000);
      // Interrupt mode: underrun without, none with, the end command
      host_u.wr(his_pkg::OFF_CMD_A, 32'h00000002);
      pe(0, 12'h002);
      pe(0, 12'h001);
      irq_is(0);
      rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h02);
      rd(his_pkg::OFF_EXT_A, 8'h01);
      host_u.wr(his_pkg::OFF_CMD_A, 32'h00000002);
      host_u.wr(his_pkg::OFF_CMD_A, 32'h00000008);
      pe(0, 12'h002);
      pe(0, 12'h001);
      irq_is(1);
      // Transparent send on B so emptied halves count as pool ready
      host_u.wr(his_pkg::OFF_CMD_B, 32'h00000002);
      // Eight B sources: line drops, pointer or own bit, read clears
      for (int i = 0; i < 8; i++) begin
         pe(1, EVM[i]);
         irq_is(0);
         if (i < 5) rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, EXP[i]);
         else begin
            rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h01);
            rd(his_pkg::OFF_EXT_B, EXP[i]);
         end
         irq_is(1);
      end
      pe(1, 12'h080);
      irq_is(1);
      host_u.wr(his_pkg::OFF_CTL2_B, 32'h00000001);
      @(negedge clk_sys);
      chk("rie_b", {33'h0, rie_b}, 34'h1);
      pe(1, 12'h080);
      rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h01);
      rd(his_pkg::OFF_EXT_B, 8'h08);
      host_u.wr(his_pkg::OFF_CMD_B, 32'h00000001);
      rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h08);
      // Random mask with pool-full masked, then unmasked while pending
      m = 8'($urandom) | 8'h20;
      host_u.wr(his_pkg::OFF_MASK_B, {24'h000000, m});
      pe(1, 12'h800);
      irq_is(1);
      host_u.wr(his_pkg::OFF_MASK_B, {24'h000000, m & 8'hDF});
      irq_is(0);
      rd(his_pkg::OFF_MASK_B, m & 8'hDF);
      host_u.reedge(his_pkg::OFF_MASK_B, 8'h00);
      irq_is(0);
      rd(his_pkg::OFF_CHANNEL_B_INTERRUPT_STATUS, 8'h20);
      irq_is(1);
      m = 8'($urandom);
      host_u.wr(his_pkg::OFF_TXL_B, {24'h000000, m});
      rd(his_pkg::OFF_TXL_B, m);
      // Unmapped read answers with an error and zero data
      exq.push_back({his_pkg::RESP_ERR, 32'h00000000});
      host_u.rd(8'h40);
      tally_and_finish();
   end
endmodule // his_top_test
